// ### rtl/scp_pkg.sv
// package: port map, field positions, reset values and divider counts of the serial port glue
package scp_pkg;
  // i/o port numbers on the low address byte
  localparam logic [7:0] PORT_TX_DATA     = 8'h40;
  localparam logic [7:0] PORT_RX_DATA     = 8'h40;
  localparam logic [7:0] PORT_MODE_CMD    = 8'h41;
  localparam logic [7:0] PORT_STATUS      = 8'h41;
  localparam logic [7:0] PORT_BACKCHAN    = 8'h60;
  localparam logic [7:0] PORT_LINE_STATUS = 8'h61;
  localparam logic [7:0] PORT_STRAPS      = 8'h62;
  // decoder outputs on a4..a7
  localparam logic [3:0] DEC_USART        = 4'h4;
  localparam logic [3:0] DEC_AUX          = 4'h6;
  localparam logic [1:0] AUX_LINE_STATUS  = 2'h1;
  localparam logic [1:0] AUX_STRAPS       = 2'h2;
  // backchannel latch fields
  localparam int         BC_CLK_SEL_BIT   = 6;
  localparam int         BC_MOD_ON_BIT    = 7;
  localparam logic [1:0] BC_RESET         = 2'h0;
  // line status port fields
  localparam int         LS_DCD_BIT       = 0;
  localparam int         LS_CALL_IND_BIT  = 1;
  // usart status, mode and command fields
  localparam int         ST_TX_READY_BIT  = 0;
  localparam int         ST_RX_READY_BIT  = 1;
  localparam int         ST_TX_EMPTY_BIT  = 2;
  localparam int         ST_OVERRUN_BIT   = 4;
  localparam int         ST_DSR_BIT       = 7;
  localparam logic [7:0] MODE_RESET       = 8'h00;
  localparam logic [7:0] CMD_RESET        = 8'h00;
  localparam int         CMD_TX_EN_BIT    = 0;
  localparam int         CMD_RX_EN_BIT    = 2;
  localparam int         CMD_DTR_BIT      = 1;
  localparam int         CMD_RTS_BIT      = 5;
  // clocks: 2.5 MHz divided by 130 gives 16x1200, then by 16 gives 16x75
  localparam int         SYS_CLK_KHZ      = 2500;
  localparam int         MAIN_DIV         = 130;
  localparam int         BACK_DIV         = 16;
  localparam int         OVERSAMPLE       = 16;
  localparam int         BAUD_SEL_W       = 4;
  localparam int         FIFO_DEPTH       = 4;
  localparam int         DATA_W           = 8;
endpackage

// ### rtl/scp_fifo_if.sv
// interface: valid/ready stream into and out of the transmit fifo
`timescale 1ns/1ps
interface scp_fifo_if;
  logic       in_valid;
  logic       in_ready;
  logic [7:0] in_data;
  logic       out_valid;
  logic       out_ready;
  logic [7:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// ### rtl/scp_fifo.sv
// module: small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module scp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  scp_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign f.in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign f.out_valid = (cnt_q != '0);
  assign f.out_data  = mem_q[rd_q];
  assign push        = f.in_valid && f.in_ready;
  assign pop         = f.out_valid && f.out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= f.in_data[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)  rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // scp_fifo

// ### rtl/scp_port_logic.sv
// module: i/o decode, uart core, baud dividers and backchannel latch for a serial cartridge
// Operation
// RULE1 - decoder looks at a4..a7 on i/o cycles, a0 picks command or data
// RULE2 - first write to port 41 after reset loads mode, later writes load command
// RULE3 - reading port 41 returns the uart status byte
// RULE4 - writing port 40 queues the byte as next character to send
// RULE5 - reading port 40 returns the last received character
// RULE6 - system clock divided by 130 gives the 16x 1200 baud clock
// RULE7 - a further divide by 16 gives the 16x 75 baud backchannel clock
// RULE8 - two-bit latch takes data bits on an output to port 60; the code ignores the write on the general board
// RULE9 - latch bit 6 selects the slow transmit clock and forces clear-to-send
// RULE10 - latch bit 7 drives the backchannel modulator enable output
// RULE11 - the uart is selected when a4..a7 equal 4; the code also needs a1..a3 low
// RULE12 - decoder output 6 with a0 and a1 enables the auxiliary input ports; the code also needs a2..a3 low and the general board
// RULE13 - reading port 61 returns carrier detect and call indicator; the code answers only on the general board
// RULE14 - reading port 62 returns the user strap bank; the code answers only on the general board
// RULE15 - on the general board one closed switch picks the baud rate divider
// RULE16 - the backchannel latch clears on reset
`timescale 1ns/1ps
module scp_port_logic (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  input  wire logic       iorq_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       rxd,
  output logic            txd,
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       dcd_n,
  input  wire logic       call_indicator_input_n,
  output logic            rts_n,
  output logic            dtr_n,
  output logic            backchannel_modulator_on,
  input  wire logic [3:0] baud_select_switches,
  input  wire logic       general_board,
  input  wire logic [7:0] user_strap_bank
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 37;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] raw;
  assign raw = {addr, data_in, iorq_n, rd_n, wr_n, rxd, cts_n, dsr_n, dcd_n,
                call_indicator_input_n, baud_select_switches, general_board, user_strap_bank};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= {NSYNC{1'b1}};
      sync2_q <= {NSYNC{1'b1}};
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end
  logic [7:0] a_s;
  logic [7:0] d_s;
  logic       iorq_s;
  logic       rd_s;
  logic       wr_s;
  logic       rxd_s;
  logic       cts_s;
  logic       dsr_s;
  logic       dcd_s;
  logic       call_ind_s;
  logic [3:0] baud_sw_s;
  logic       gen_s;
  logic [7:0] strap_s;
  assign {a_s, d_s, iorq_s, rd_s, wr_s, rxd_s, cts_s, dsr_s, dcd_s, call_ind_s,
          baud_sw_s, gen_s, strap_s} = sync2_q;

  // ----------------------------------------------------------------
  // port decode
  // ----------------------------------------------------------------
  logic io_rd;
  logic io_wr;
  logic wr_prev_q;
  logic rd_prev_q;
  logic wr_pulse;
  logic rd_pulse;
  logic sel_usart;
  logic sel_aux;
  assign io_rd     = !iorq_s && !rd_s;
  assign io_wr     = !iorq_s && !wr_s;
  assign sel_usart = (a_s[7:4] == scp_pkg::DEC_USART) && (a_s[3:1] == 3'h0); // RULE1 RULE11
  assign sel_aux   = (a_s[7:4] == scp_pkg::DEC_AUX) && (a_s[3:2] == 2'h0); // RULE12
  assign wr_pulse  = io_wr && !wr_prev_q;
  assign rd_pulse  = io_rd && !rd_prev_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
    end else begin
      wr_prev_q <= io_wr;
      rd_prev_q <= io_rd;
    end
  end

  // ----------------------------------------------------------------
  // baud dividers
  // ----------------------------------------------------------------
  logic [7:0]  main_cnt_q;
  logic        tick16_main_q;
  logic [3:0]  back_cnt_q;
  logic        tick16_back_q;
  logic [10:0] gen_cnt_q;
  logic [10:0] gen_div;
  logic        tick16_gen_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      main_cnt_q    <= 8'h00;
      tick16_main_q <= 1'b0;
    end else begin
      tick16_main_q <= (main_cnt_q == 8'(scp_pkg::MAIN_DIV - 1)); // RULE6
      main_cnt_q    <= (main_cnt_q == 8'(scp_pkg::MAIN_DIV - 1)) ? 8'h00 : main_cnt_q + 8'h01;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      back_cnt_q    <= 4'h0;
      tick16_back_q <= 1'b0;
    end else begin
      tick16_back_q <= 1'b0;
      if (tick16_main_q) begin
        back_cnt_q    <= back_cnt_q + 4'h1;
        tick16_back_q <= (back_cnt_q == 4'(scp_pkg::BACK_DIV - 1)); // RULE7
      end
    end
  end
  // switch 0 -> 1200, 1 -> 600, 2 -> 300, 3 -> 2400; none closed keeps 1200
  always_comb begin
    gen_div = 11'(scp_pkg::MAIN_DIV); // RULE15
    if (!baud_sw_s[3]) gen_div = 11'(scp_pkg::MAIN_DIV / 2);
    if (!baud_sw_s[2]) gen_div = 11'(scp_pkg::MAIN_DIV * 4);
    if (!baud_sw_s[1]) gen_div = 11'(scp_pkg::MAIN_DIV * 2);
    if (!baud_sw_s[0]) gen_div = 11'(scp_pkg::MAIN_DIV);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gen_cnt_q    <= 11'h000;
      tick16_gen_q <= 1'b0;
    end else begin
      tick16_gen_q <= (gen_cnt_q >= gen_div - 11'h001);
      gen_cnt_q    <= (gen_cnt_q >= gen_div - 11'h001) ? 11'h000 : gen_cnt_q + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // backchannel latch and clock mux
  // ----------------------------------------------------------------
  logic [1:0] bc_q;
  logic       tx_clock_mux;
  logic       rx_tick;
  logic       cts_eff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bc_q <= scp_pkg::BC_RESET; // RULE16
    end else if (wr_pulse && !gen_s && a_s == scp_pkg::PORT_BACKCHAN) begin
      bc_q <= {d_s[scp_pkg::BC_MOD_ON_BIT], d_s[scp_pkg::BC_CLK_SEL_BIT]}; // RULE8
    end
  end
  assign tx_clock_mux = gen_s ? tick16_gen_q : (bc_q[0] ? tick16_back_q : tick16_main_q); // RULE9
  assign rx_tick      = gen_s ? tick16_gen_q : tick16_main_q;
  assign cts_eff      = (!gen_s && bc_q[0]) ? 1'b1 : !cts_s; // RULE9

  // ----------------------------------------------------------------
  // mode and command registers
  // ----------------------------------------------------------------
  logic       mode_done_q;
  logic [7:0] mode_q;
  logic [7:0] cmd_q;
  logic       wr_ctrl;
  logic       wr_data;
  assign wr_ctrl = wr_pulse && sel_usart && a_s[0];
  assign wr_data = wr_pulse && sel_usart && !a_s[0];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_done_q <= 1'b0;
      mode_q      <= scp_pkg::MODE_RESET;
      cmd_q       <= scp_pkg::CMD_RESET;
    end else if (wr_ctrl) begin
      if (!mode_done_q) begin
        mode_q      <= d_s; // RULE2
        mode_done_q <= 1'b1;
      end else begin
        cmd_q <= d_s; // RULE2
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit path through the fifo
  // ----------------------------------------------------------------
  scp_fifo_if tx_if ();
  scp_fifo #(.WIDTH(scp_pkg::DATA_W), .DEPTH(scp_pkg::FIFO_DEPTH)) u_tx_fifo (
    .clk     (clk),
    .reset_n (reset_n),
    .f       (tx_if.fifo)
  );
  logic       tx_busy_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic [3:0] tx_ph_q;
  logic       tx_start;
  assign tx_if.in_valid  = wr_data; // RULE4
  assign tx_if.in_data   = d_s;
  assign tx_start        = !tx_busy_q && tx_if.out_valid && cts_eff && cmd_q[scp_pkg::CMD_TX_EN_BIT];
  assign tx_if.out_ready = tx_start;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_busy_q <= 1'b0;
      tx_sh_q   <= 10'h3ff;
      tx_bits_q <= 4'h0;
      tx_ph_q   <= 4'h0;
      txd       <= 1'b1;
    end else if (tx_start) begin
      tx_busy_q <= 1'b1;
      tx_sh_q   <= {1'b1, tx_if.out_data, 1'b0};
      tx_bits_q <= 4'h0;
      tx_ph_q   <= 4'h0;
    end else if (tx_busy_q && tx_clock_mux) begin
      tx_ph_q <= tx_ph_q + 4'h1;
      if (tx_ph_q == 4'h0) begin
        txd     <= tx_sh_q[0];
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      end
      if (tx_ph_q == 4'(scp_pkg::OVERSAMPLE - 1)) begin
        tx_bits_q <= tx_bits_q + 4'h1;
        if (tx_bits_q == 4'h9) tx_busy_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  logic       rx_busy_q;
  logic [3:0] rx_ph_q;
  logic [3:0] rx_bits_q;
  logic [7:0] rx_sh_q;
  logic [7:0] rx_data_q;
  logic       rx_rdy_q;
  logic       overrun_q;
  logic       rx_done;
  logic       rd_rx;
  assign rd_rx   = rd_pulse && sel_usart && !a_s[0];
  assign rx_done = rx_busy_q && rx_tick && rx_ph_q == 4'(scp_pkg::OVERSAMPLE - 1)
                   && rx_bits_q == 4'h8;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_busy_q <= 1'b0;
      rx_ph_q   <= 4'h0;
      rx_bits_q <= 4'h0;
      rx_sh_q   <= 8'h00;
    end else if (!rx_busy_q) begin
      if (!rxd_s && cmd_q[scp_pkg::CMD_RX_EN_BIT]) begin
        rx_busy_q <= 1'b1;
        rx_ph_q   <= 4'h8;
        rx_bits_q <= 4'h0;
      end
    end else if (rx_tick) begin
      rx_ph_q <= rx_ph_q + 4'h1;
      if (rx_ph_q == 4'(scp_pkg::OVERSAMPLE - 1)) begin
        rx_bits_q <= rx_bits_q + 4'h1;
        if (rx_bits_q != 4'h0 && rx_bits_q != 4'h9) rx_sh_q <= {rxd_s, rx_sh_q[7:1]};
        // stay busy until the middle of the stop bit so a low last data bit is not a new start
        if (rx_bits_q == 4'h9) rx_busy_q <= 1'b0;
      end
    end
  end
  // a character arriving in the read cycle wins over the read clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_data_q <= 8'h00;
      rx_rdy_q  <= 1'b0;
      overrun_q <= 1'b0;
    end else if (rx_done) begin
      rx_data_q <= {rxd_s, rx_sh_q[7:1]};
      rx_rdy_q  <= 1'b1;
      if (rx_rdy_q && !rd_rx) overrun_q <= 1'b1;
    end else if (rd_rx) begin
      rx_rdy_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read mux and modem outputs
  // ----------------------------------------------------------------
  logic [7:0] status;
  logic [7:0] rd_mux;
  logic       rd_hit;
  always_comb begin
    status = 8'h00;
    status[scp_pkg::ST_TX_READY_BIT] = tx_if.in_ready && cts_eff;
    status[scp_pkg::ST_RX_READY_BIT] = rx_rdy_q;
    status[scp_pkg::ST_TX_EMPTY_BIT] = !tx_busy_q && !tx_if.out_valid;
    status[scp_pkg::ST_OVERRUN_BIT]  = overrun_q;
    status[scp_pkg::ST_DSR_BIT]      = !dsr_s;
  end
  always_comb begin
    rd_mux = 8'h00;
    rd_hit = 1'b1;
    if (sel_usart && a_s[0]) begin
      rd_mux = status; // RULE3
    end else if (sel_usart) begin
      rd_mux = rx_data_q; // RULE5
    end else if (sel_aux && gen_s && a_s[1:0] == scp_pkg::AUX_LINE_STATUS) begin
      rd_mux[scp_pkg::LS_DCD_BIT] = !dcd_s; // RULE13
      rd_mux[scp_pkg::LS_CALL_IND_BIT] = !call_ind_s; // RULE13
    end else if (sel_aux && gen_s && a_s[1:0] == scp_pkg::AUX_STRAPS) begin
      rd_mux = strap_s; // RULE14
    end else begin
      rd_hit = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out                 <= 8'h00;
      data_oe                  <= 1'b0;
      rts_n                    <= 1'b1;
      dtr_n                    <= 1'b1;
      backchannel_modulator_on <= 1'b0;
    end else begin
      data_out                 <= rd_mux;
      data_oe                  <= io_rd && rd_hit;
      rts_n                    <= !cmd_q[scp_pkg::CMD_RTS_BIT];
      dtr_n                    <= !cmd_q[scp_pkg::CMD_DTR_BIT];
      backchannel_modulator_on <= bc_q[1]; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_main_div_period: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
    $rose(tick16_main_q) |=> !tick16_main_q[*8])
    else $error("main divider ticks too often");
  a_main_div_wrap: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
    main_cnt_q == 8'(scp_pkg::MAIN_DIV - 1) |=> tick16_main_q && main_cnt_q == 8'h00)
    else $error("main divider does not wrap at 130");
  a_back_div_rate: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
    tick16_back_q |-> $past(tick16_main_q) && $past(back_cnt_q) == 4'hf)
    else $error("backchannel tick without 16 main ticks");
  a_bc_latch_load: assert property (@(posedge clk) disable iff (!reset_n) // RULE8
    wr_pulse && !gen_s && a_s == scp_pkg::PORT_BACKCHAN
    |=> bc_q == {$past(d_s[scp_pkg::BC_MOD_ON_BIT]), $past(d_s[scp_pkg::BC_CLK_SEL_BIT])})
    else $error("backchannel latch not loaded");
  a_bc_clock_mux: assert property (@(posedge clk) disable iff (!reset_n) // RULE9
    !gen_s && bc_q[0] |-> tx_clock_mux == tick16_back_q && cts_eff)
    else $error("backchannel clock or cts not forced");
  a_mod_on_follow: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
    ##1 backchannel_modulator_on == $past(bc_q[1]))
    else $error("modulator enable does not follow latch");
  a_mode_then_cmd: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
    wr_ctrl && mode_done_q |=> cmd_q == $past(d_s) && mode_q == $past(mode_q))
    else $error("later write to 41 changed mode");
  a_tx_queue: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
    wr_data && tx_if.in_ready && !tx_if.out_ready |=> tx_if.out_valid)
    else $error("written byte not queued");
  a_status_read: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
    io_rd && a_s == scp_pkg::PORT_STATUS |=> data_oe && data_out == $past(status))
    else $error("status read wrong");
  a_strap_read: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
    io_rd && gen_s && a_s == scp_pkg::PORT_STRAPS |=> data_out == $past(strap_s))
    else $error("strap read wrong");
endmodule // scp_port_logic

// ### dv/scp_modem_model.sv
// partner: v24 modem that sends and receives 8n1 characters
`timescale 1ns/1ps
module scp_modem_model (
  input  wire logic clk,
  output logic      rxd,
  input  wire logic txd,
  output logic      cts_n,
  output logic      dsr_n,
  output logic      dcd_n,
  output logic      call_indicator_input_n,
  input  wire logic rts_n,
  input  wire logic dtr_n
);
  logic carrier_n = 1'b0;
  logic ring_n    = 1'b1;
  initial rxd = 1'b1;
  // clear-to-send only answers a raised request to send
  assign cts_n = rts_n;
  assign dsr_n = dtr_n;
  assign dcd_n = carrier_n;
  assign call_indicator_input_n = ring_n;
  // ------------------------------------------------------------
  // character transfer, lsb first, one start and one stop bit
  // ------------------------------------------------------------
  task automatic send_char(input logic [7:0] b, input int bit_clks);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (bit_clks - 1) @(posedge clk);
    end
  endtask
  task automatic get_char(input int bit_clks, output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (txd !== 1'b0 && n < 40 * bit_clks) begin
      @(posedge clk);
      n++;
    end
    repeat (bit_clks / 2) @(posedge clk);
    ok = (txd === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge clk);
      b[i] = txd;
    end
    repeat (bit_clks) @(posedge clk);
    ok = ok && (txd === 1'b1);
  endtask
endmodule // scp_modem_model

// ### dv/serial_cartridge_port_logic_bench.sv
// bench: self-checking test of the serial cartridge port logic
`timescale 1ns/1ps
module serial_cartridge_port_logic_bench;
  localparam int DLY = 2;
  logic       clk         = 1'b0;
  logic       reset_n     = 1'b0;
  logic [7:0] addr        = 8'h00;
  logic [7:0] data_in     = 8'h00;
  logic [7:0] data_out;
  logic       data_oe;
  logic       iorq_n      = 1'b1;
  logic       rd_n        = 1'b1;
  logic       wr_n        = 1'b1;
  logic       rxd;
  logic       txd;
  logic       cts_n;
  logic       dsr_n;
  logic       dcd_n;
  logic       ci_n;
  logic       rts_n;
  logic       dtr_n;
  logic       mod_on;
  logic [3:0] baud_sel    = 4'he;
  logic       gen_board   = 1'b1;
  logic [7:0] straps      = 8'h5a;
  int         n_fail      = 0;
  int         compares    = 0;

  scp_port_logic scp_port_logic_i (
    .clk(clk), .reset_n(reset_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .iorq_n(iorq_n), .rd_n(rd_n), .wr_n(wr_n), .rxd(rxd), .txd(txd),
    .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .call_indicator_input_n(ci_n),
    .rts_n(rts_n), .dtr_n(dtr_n), .backchannel_modulator_on(mod_on),
    .baud_select_switches(baud_sel), .general_board(gen_board), .user_strap_bank(straps));
  scp_modem_model scp_modem_model_i (
    .clk(clk), .rxd(rxd), .txd(txd), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n),
    .call_indicator_input_n(ci_n), .rts_n(rts_n), .dtr_n(dtr_n));

  initial begin
    forever #20 clk = ~clk;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one i/o cycle; strobes held five clocks, answer sampled before release
  task automatic io(input logic [7:0] a, input logic wr, input logic [7:0] d,
                    output logic [7:0] q, output logic oe);
    @(posedge clk);
    #DLY;
    addr = a;
    data_in = d;
    iorq_n = 1'b0;
    wr_n = ~wr;
    rd_n = wr;
    repeat (5) @(posedge clk);
    #DLY;
    q = data_out;
    oe = data_oe;
    iorq_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    repeat (5) @(posedge clk);
    #DLY;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("reset outputs", {3'h0, data_oe, txd, rts_n, dtr_n, mod_on}, 8'h0e);
    $display("test reset done");
  endtask
  task automatic t_mode_cmd();
    logic [7:0] q;
    logic oe;
    io(8'h41, 1'b1, 8'h22, q, oe);
    chk("mode write modem lines", {6'h0, rts_n, dtr_n}, 8'h03);
    io(8'h41, 1'b1, 8'h27, q, oe);
    chk("command modem lines", {6'h0, rts_n, dtr_n}, 8'h00);
    io(8'h41, 1'b0, 8'h00, q, oe);
    chk("status enable", {7'h0, oe}, 8'h01);
    chk("status", q & 8'h97, 8'h85);
    $display("test mode and command done");
  endtask
  task automatic t_aux();
    logic [7:0] q;
    logic oe;
    io(8'h61, 1'b0, 8'h00, q, oe);
    chk("line status", q & 8'h03, 8'h01);
    scp_modem_model_i.carrier_n = 1'b1;
    scp_modem_model_i.ring_n = 1'b0;
    io(8'h61, 1'b0, 8'h00, q, oe);
    chk("line status ring", q & 8'h03, 8'h02);
    io(8'h62, 1'b0, 8'h00, q, oe);
    chk("straps", q, 8'h5a);
    chk("straps enable", {7'h0, oe}, 8'h01);
    io(8'h63, 1'b0, 8'h00, q, oe);
    chk("aux unmapped enable", {7'h0, oe}, 8'h00);
    io(8'h50, 1'b0, 8'h00, q, oe);
    chk("unmapped enable", {7'h0, oe}, 8'h00);
    scp_modem_model_i.carrier_n = 1'b0;
    scp_modem_model_i.ring_n = 1'b1;
    $display("test auxiliary ports done");
  endtask
  task automatic t_tx();
    logic [7:0] q;
    logic [7:0] b;
    logic oe;
    logic ok;
    baud_sel = 4'h7;
    fork
      io(8'h40, 1'b1, 8'ha5, q, oe);
      scp_modem_model_i.get_char(1040, b, ok);
    join
    chk("sent char", b, 8'ha5);
    chk("sent framing", {7'h0, ok}, 8'h01);
    $display("test transmit done");
  endtask
  task automatic t_rx();
    logic [7:0] q;
    logic oe;
    int n;
    #DLY;
    baud_sel = 4'h6;
    scp_modem_model_i.send_char(8'h3c, 2080);
    n = 0;
    q = 8'h00;
    while (q[1] !== 1'b1) begin
      if (n == 20) begin
        n_fail++;
        $display("unexpected rx ready expected 01 seen 00");
        test_done();
      end
      io(8'h41, 1'b0, 8'h00, q, oe);
      n++;
    end
    io(8'h40, 1'b0, 8'h00, q, oe);
    chk("received char", q, 8'h3c);
    io(8'h41, 1'b0, 8'h00, q, oe);
    chk("rx ready after read", q & 8'h02, 8'h00);
    $display("test receive done");
  endtask
  task automatic t_backchan();
    logic [7:0] q;
    logic oe;
    int n;
    gen_board = 1'b0;
    io(8'h41, 1'b1, 8'h05, q, oe);
    io(8'h60, 1'b1, 8'hc0, q, oe);
    chk("modulator on", {7'h0, mod_on}, 8'h01);
    io(8'h40, 1'b1, 8'h55, q, oe);
    n = 0;
    while (txd !== 1'b0) begin
      if (n == 5000) begin
        n_fail++;
        $display("unexpected slow start expected 00 seen 01");
        test_done();
      end
      @(posedge clk);
      n++;
    end
    repeat (2500) @(posedge clk);
    chk("slow start bit", {7'h0, txd}, 8'h00);
    for (int i = 0; i < 5; i++) begin
      io(8'h40, 1'b1, 8'h10 + 8'(i), q, oe);
    end
    io(8'h41, 1'b0, 8'h00, q, oe);
    chk("tx room when full", q & 8'h01, 8'h00);
    io(8'h60, 1'b1, 8'h00, q, oe);
    chk("modulator off", {7'h0, mod_on}, 8'h00);
    $display("test backchannel done");
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    #DLY;
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_mode_cmd();
    t_aux();
    t_tx();
    t_rx();
    t_backchan();
    test_done();
  end
endmodule // serial_cartridge_port_logic_bench
